// [hdl/hbc_ctrl.sv]
/*
  Controller outside a half-bridge gate driver: start-up sequence, drive inputs,
  fault clear pulses, hard stop and freeze on the shared open-drain lines.
  Assumes the driver's lines are synchronous to sys_clk_i (sampled directly).
*/
//
// Summary of operation
// - In run state, controller does not start a fault clear pulse while sync line shows soft turn-off.
// - Fault clear never held high continuously in run state.
// - Fault clear held active at power-up until supplies are established.
// - Start-up: clear high, low input high, low input low, then clear low.
// - Low input pulse and clear pulse each last at least 15 us.
// - Pulling fault/shutdown line low forces hard stop; line is wired-OR.
`timescale 1ns/10ps
`default_nettype none
module hbc_ctrl
  import hbc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic supply_ok_i,          // Supplies established
  input  wire logic start_i,              // Pulse: run start-up
  input  wire logic high_req_i,           // Wanted high-side state
  input  wire logic low_req_i,            // Wanted low-side state
  input  wire logic hard_stop_i,          // Force hard stop
  input  wire logic freeze_i,             // Freeze outputs, in run state only
  input  wire logic clear_req_i,          // Pulse: clear latched fault
  input  wire logic fault_shutdown_line_i,
  input  wire logic sync_fault_line_i,
  output logic      high_in_o,
  output logic      low_in_o,
  output logic      fault_clear_in_o,
  output logic      fault_shutdown_line_o,
  output logic      fault_shutdown_line_oe_o,
  output logic      sync_fault_line_o,
  output logic      sync_fault_line_oe_o,
  output logic      running_o,
  output logic      fault_seen_o,
  output logic      soft_turnoff_seen_o
);
  // ==========================================================================
  // Start-up sequencer
  // ==========================================================================
  hbc_state_e             state_q;
  logic       [CNT_W-1:0] cnt_q;
  logic                   cnt_done;
  logic                   step_timed;
  logic                   clr_busy_q;
  logic       [CNT_W-1:0] clr_cnt_q;
  logic                   soft_active;
  logic                   clear_want;
  logic                   low_want;
  logic                   high_want;

  // Timer end marks the least pulse width of one start-up step
  assign cnt_done    = (cnt_q == CNT_W'(STARTUP_PULSE_CYC - 1));
  assign step_timed  = (state_q == HBC_CLR_PRE) || (state_q == HBC_CHARGE) || (state_q == HBC_CLR_END);
  // A low sync line that we do not pull is a driver in soft turn-off
  assign soft_active = !sync_fault_line_i && !sync_fault_line_oe_o;

  // Step sequencer: each timed step moves on only when the step timer runs out
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= HBC_IDLE;
    end else begin
      case (state_q)
        HBC_IDLE: begin
          if (start_i && supply_ok_i) begin
            state_q <= HBC_CLR_PRE;
          end
        end
        HBC_CLR_PRE: begin
          if (cnt_done) begin
            state_q <= HBC_CHARGE;
          end
        end
        HBC_CHARGE: begin
          if (cnt_done) begin
            state_q <= HBC_CLR_END;
          end
        end
        HBC_CLR_END: begin
          if (cnt_done) begin
            state_q <= HBC_RUN;
          end
        end
        HBC_RUN: begin
          // Supply loss drops back to idle, where the clear is held again
          if (!supply_ok_i) begin
            state_q <= HBC_IDLE;
          end
        end
        default: begin
          state_q <= HBC_IDLE;
        end
      endcase
    end
  end

  // Step timer: runs in the timed steps only and restarts at each step change, so no count carries over
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (!step_timed || cnt_done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Fault clear pulse in run state
  // ==========================================================================
  // One finite pulse only; a held clear would stop the driver latching faults
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_busy_q <= 1'b0;
      clr_cnt_q  <= '0;
    end else if (state_q != HBC_RUN) begin
      clr_busy_q <= 1'b0;
      clr_cnt_q  <= '0;
    end else if (clr_busy_q) begin
      if (clr_cnt_q == CNT_W'(STARTUP_PULSE_CYC - 1)) begin
        clr_busy_q <= 1'b0;
      end
      clr_cnt_q <= clr_cnt_q + CNT_W'(1);
    end else if (clear_req_i && !soft_active) begin
      clr_busy_q <= 1'b1;
      clr_cnt_q  <= '0;
    end
  end

  // ==========================================================================
  // Pin drive, registered
  // ==========================================================================
  // Clear stands high through idle and all of start-up, dropping only after the low input has
  // fallen; the price is that the driver cannot latch faults while we wait in idle for start_i
  assign clear_want = (state_q == HBC_IDLE)
                   || (state_q == HBC_CLR_PRE) || (state_q == HBC_CHARGE)
                   || (state_q == HBC_CLR_END)
                   || (state_q == HBC_RUN && clr_busy_q);
  // Both requests high asks for neither side, so the driver never sees both inputs high
  assign low_want   = (state_q == HBC_CHARGE) ||
                      (state_q == HBC_RUN && low_req_i && !high_req_i);
  assign high_want  = (state_q == HBC_RUN && high_req_i && !low_req_i);

  // Fault clear pin
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_clear_in_o <= 1'b0;
    end else begin
      fault_clear_in_o <= clear_want;
    end
  end

  // Low-side drive input: the charge step, or a low request in run
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_in_o <= 1'b0;
    end else begin
      low_in_o <= low_want;
    end
  end

  // High-side drive input: only in run, never during the bootstrap charge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_in_o <= 1'b0;
    end else begin
      high_in_o <= high_want;
    end
  end

  // Fault/shutdown line: pulled low only while a hard stop is asked for; peers share it wired-OR
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_shutdown_line_oe_o <= 1'b0;
    end else begin
      fault_shutdown_line_oe_o <= hard_stop_i;
    end
  end

  // Sync line: freeze is pulled only in run, where holding the gates means something
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_fault_line_oe_o <= 1'b0;
    end else begin
      sync_fault_line_oe_o <= freeze_i && (state_q == HBC_RUN);
    end
  end

  // Open-drain lines: only ever drive low
  assign fault_shutdown_line_o = 1'b0;
  assign sync_fault_line_o     = 1'b0;

  // ==========================================================================
  // Run flag and status seen on the shared lines
  // ==========================================================================
  // Run flag for the user side
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= (state_q == HBC_RUN);
    end
  end

  // A low fault line not driven by us is a driver fault or supply undervolt
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_seen_o <= 1'b0;
    end else begin
      fault_seen_o <= !fault_shutdown_line_i && !fault_shutdown_line_oe_o;
    end
  end

  // Soft turn-off seen; a freeze of our own is masked out
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_turnoff_seen_o <= 1'b0;
    end else begin
      soft_turnoff_seen_o <= soft_active;
    end
  end
endmodule // hbc_ctrl
`default_nettype wire

// [hdl/hbc_pkg.sv]
/*
  Package for the half-bridge driver controller: timing counts and state encoding.
  Assumes a 125 MHz system clock.
*/
`default_nettype none
package hbc_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned STARTUP_PULSE_US = 15;     // Least start-up pulse width
  localparam int unsigned STARTUP_PULSE_CYC = STARTUP_PULSE_US * CLK_MHZ; // 1875, rounds exactly
  localparam int unsigned CNT_W            = 12;

  // ==========================================================================
  // Controller states (Gray along the usual path)
  // ==========================================================================
  typedef enum logic [2:0] {
    HBC_IDLE    = 3'b000,
    HBC_CLR_PRE = 3'b001,
    HBC_CHARGE  = 3'b011,
    HBC_CLR_END = 3'b010,
    HBC_RUN     = 3'b110
  } hbc_state_e;
endpackage : hbc_pkg
`default_nettype wire

// [test/hbc_ctrl_monitor.sv]
/* Checker on the hbc_ctrl ports.
   Bound below to every hbc_ctrl instance. */
`timescale 1ns/10ps
`default_nettype none
module hbc_ctrl_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic high_req_i,
  input wire logic low_req_i,
  input wire logic hard_stop_i,
  input wire logic sync_fault_line_i,
  input wire logic high_in_o,
  input wire logic low_in_o,
  input wire logic fault_clear_in_o,
  input wire logic fault_shutdown_line_oe_o,
  input wire logic sync_fault_line_oe_o,
  input wire logic running_o
);
  // ==========================================================================
  // Pulse widths, counted while each pin stands high
  // ==========================================================================
  logic [15:0] lo_q, cl_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) {lo_q, cl_q} <= '0;
    // Clear count saturates: idle may hold the clear longer than the counter spans
    else {lo_q, cl_q} <= {low_in_o ? lo_q + 16'h1 : 16'h0, fault_clear_in_o ? cl_q + {15'h0, ~&cl_q} : 16'h0};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_lo_end; $fell(low_in_o) && !running_o; endsequence
  sequence s_cl_end; $fell(fault_clear_in_o); endsequence
  a_no_both_on: assert property (!(high_in_o && low_in_o)) else $error("both on");
  a_follow_high: assert property (running_o && supply_ok_i |=>
    high_in_o == ($past(high_req_i) && !$past(low_req_i))) else $error("high input");
  a_follow_low: assert property (running_o && supply_ok_i |=>
    low_in_o == ($past(low_req_i) && !$past(high_req_i))) else $error("low input");
  a_lo_pulse_len: assert property (s_lo_end |-> lo_q == 16'h753 && fault_clear_in_o)
    else $error("low pulse");
  a_clr_pulse_len: assert property (s_cl_end |-> cl_q >= 16'h753) else $error("clear pulse");
  a_pwrup_clear: assert property (!supply_ok_i && !running_o |-> ##[1:2] fault_clear_in_o)
    else $error("no clear at power-up");
  a_clr_ssd_block: assert property (running_o && !sync_fault_line_i && !sync_fault_line_oe_o |=>
    !$rose(fault_clear_in_o)) else $error("clear in soft turn-off");
  a_hard_stop: assert property (1'b1 |=> fault_shutdown_line_oe_o == $past(hard_stop_i))
    else $error("hard stop");
endmodule // hbc_ctrl_monitor
bind hbc_ctrl hbc_ctrl_monitor hbc_ctrl_monitor_inst (.*);
`default_nettype wire

// [test/hbc_drv_model.sv]
/* Behavioural gate driver facing hbc_ctrl.
   Assumes the bench resolves both lines with pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module hbc_drv_model #(parameter int SSD_CYC = 20) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic h_i,
  input  wire logic l_i,
  input  wire logic clr_i,
  input  wire logic flt_i,
  input  wire logic syn_i,
  input  wire logic desat_i,
  input  wire logic uvl_i,
  input  wire logic uvf_i,
  output logic      hg_o,
  output logic      lg_o,
  output logic      foe_o,
  output logic      soe_o
);
  // ==========================================================================
  // Gate and fault state, sampled on the clock
  // ==========================================================================
  logic [7:0] ssd_q;
  logic       lat_q, arm_q;
  assign foe_o = lat_q || uvl_i;
  assign soe_o = ssd_q != 8'h0; // Let go by itself at the end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {hg_o, lg_o, lat_q, arm_q, ssd_q} <= '0;
    end else if (soe_o) begin
      {hg_o, lg_o} <= 2'h0; // Only the pull-down acts
      ssd_q <= ssd_q - 8'h1;
      if (ssd_q == 8'h1) lat_q <= !clr_i; // Held clear blocks the latch
    end else if (desat_i && (hg_o || lg_o)) begin
      ssd_q <= 8'(SSD_CYC);
    end else if (!flt_i) begin
      {hg_o, lg_o} <= 2'h0; // Shutdown wins over freeze, not latched
      if (clr_i) lat_q <= 1'b0;
    end else if (syn_i) begin // Low sync line freezes both gates and the arm flag
      arm_q <= !uvf_i && (arm_q || !h_i); // Needs a fresh rising edge
      hg_o <= h_i && !l_i && arm_q && !uvf_i;
      lg_o <= l_i && !h_i;
    end
  end
endmodule // hbc_drv_model
`default_nettype wire

// [test/tb.sv]
/* Bench for hbc_ctrl against a behavioural driver.
   Assumes the monitor binds itself. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hbc_pkg::*;
  logic clk = 0, rst_n = 0, sup = 0, st = 0, hr = 0, lr = 0, hs = 0, fz = 0, cr = 0, ds = 0, uvl = 0, uvf = 0;
  logic hin, lin, clr, foe, soe, run, fse, sse, hg, lg, mfoe, msoe, pl = 0;
  wire  flt = !(foe || mfoe);
  wire  syn = !(soe || msoe);
  int   error_cnt = 0, n_compared = 0, nl = 0;
  initial forever #4 clk = !clk;
  hbc_ctrl hbc_ctrl_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .supply_ok_i(sup), .start_i(st), .high_req_i(hr),
    .low_req_i(lr), .hard_stop_i(hs), .freeze_i(fz), .clear_req_i(cr), .fault_shutdown_line_i(flt),
    .sync_fault_line_i(syn), .high_in_o(hin), .low_in_o(lin), .fault_clear_in_o(clr), .fault_shutdown_line_o(),
    .fault_shutdown_line_oe_o(foe), .sync_fault_line_o(), .sync_fault_line_oe_o(soe), .running_o(run),
    .fault_seen_o(fse), .soft_turnoff_seen_o(sse));
  hbc_drv_model hbc_drv_model_inst (.clk_i(clk), .rst_n_i(rst_n), .h_i(hin), .l_i(lin), .clr_i(clr), .flt_i(flt),
    .syn_i(syn), .desat_i(ds), .uvl_i(uvl), .uvf_i(uvf), .hg_o(hg), .lg_o(lg), .foe_o(mfoe), .soe_o(msoe));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog, about two and a half times the expected run
  initial begin
    #150000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence; inputs move only by NBA on the rising edge
  initial begin
    void'($urandom(32'h8B2D6892));
    w(12);
    rst_n <= 1'b1;
    w(3);
    chk(clr, 1'b1, "clear at power-up");
    chk(hin || lin, 1'b0, "idle drive");
    {sup, st} <= 2'h3;
    w(1);
    st <= 1'b0;
    for (int k = 0; k < 7000 && !run; k++) begin
      nl += int'(lin);
      if (pl && !lin) chk(clr, 1'b1, "clear outlasts charge");
      pl = lin;
      w(1);
    end
    chk(nl == STARTUP_PULSE_CYC, 1'b1, "charge pulse");
    chk(run, 1'b1, "running");
    $display("startup test done");
    repeat (40) begin
      {hr, lr} <= 2'($urandom);
      w(3);
      chk(hg, hr && !lr, "high gate");
      chk(lg, lr && !hr, "low gate");
      chk(hin, hr && !lr, "high input");
      chk(lin, lr && !hr, "low input");
    end
    {hr, lr, fz} <= 3'h4;
    w(3);
    fz <= 1'b1;
    w(2);
    {hr, lr} <= 2'h1;
    w(4);
    chk(hg && !lg && !syn, 1'b1, "freeze");
    {hr, lr, fz, hs} <= 4'h9;
    w(3);
    chk(hg || flt, 1'b0, "hard stop");
    {hs, uvf} <= 2'h1;
    w(3);
    chk(hg, 1'b0, "float undervolt");
    uvf <= 1'b0;
    w(3);
    chk(hg, 1'b0, "no fresh edge");
    hr <= 1'b0;
    w(3);
    {hr, uvl} <= 2'h3;
    w(3);
    chk(fse && !hg, 1'b1, "low undervolt");
    uvl <= 1'b0;
    w(3);
    chk(hg && !fse, 1'b1, "recovered");
    $display("drive test done");
    ds <= 1'b1;
    w(1);
    {ds, cr} <= 2'h0;
    w(3);
    chk(sse, 1'b1, "soft turn-off seen");
    cr <= 1'b1;
    w(1);
    cr <= 1'b0;
    w(28);
    chk(clr || !fse || hg || !syn, 1'b0, "latched fault");
    cr <= 1'b1;
    w(1);
    cr <= 1'b0;
    w(3);
    chk(clr, 1'b1, "clear pulse");
    w(1880);
    chk(clr || fse || !hg, 1'b0, "fault cleared");
    $display("fault test done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
